// file: hw/rtcfe_pkg.sv
// Package for the real-time clock register front end.
// Assumes a 25 MHz system clock; all timebase rates are derived from it.
package rtcfe_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int BASE_TICK_HZ = 65536;
  localparam int BASE_TICK_CYC = SYS_CLK_HZ / BASE_TICK_HZ;
  localparam int DIV_W = 17;
  localparam int PRE_W = 9;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_SEC = 4'h2;
  localparam logic [3:0] ADDR_MIN = 4'h3;
  localparam logic [3:0] ADDR_HOUR = 4'h4;
  localparam logic [3:0] ADDR_DAY = 4'h5;
  localparam logic [3:0] ADDR_WDAY = 4'h6;
  localparam logic [3:0] ADDR_MON = 4'h7;
  localparam logic [3:0] ADDR_YEAR = 4'h8;
  localparam logic [3:0] ADDR_ALM_FIRST = 4'h9;
  localparam logic [3:0] ADDR_ALM_LAST = 4'hC;
  localparam logic [3:0] ADDR_OFFSET = 4'hD;
  localparam logic [3:0] ADDR_TMR_MODE = 4'hE;
  localparam logic [3:0] ADDR_CDOWN = 4'hF;
  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int CMD_READ_BIT = 7;
  localparam int C1_STOP = 5;
  localparam int C2_MI = 7;
  localparam int C2_SI = 6;
  localparam int C2_MSF = 5;
  localparam int C2_AF = 3;
  localparam int C2_TF = 2;
  localparam int C2_AIE = 1;
  localparam int C2_TIE = 0;
  localparam int TM_TE = 3;
  localparam int TM_CTD_LSB = 0;
  localparam int TM_COF_LSB = 4;
  localparam logic [7:0] C2_FLAG_MASK = 8'h2C;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h58;
  // ****************************************
  // BCD limits
  // ****************************************
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX = 8'h06;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // ****************************************
  // Reset values and writable bits, index 15 first
  // ****************************************
  localparam logic [15:0][7:0] REG_RST = {8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00,
                                          8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  localparam logic [15:0][7:0] REG_MASK = {8'hFF, 8'h7B, 8'hFF, 8'h87, 8'hBF, 8'hBF, 8'hFF, 8'hFF,
                                           8'h1F, 8'h07, 8'h3F, 8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hA6};
endpackage : rtcfe_pkg

// file: hw/rtcfe_top.sv
// Serial register front end of a real-time clock with calendar, countdown timer and clock output.
// Assumes the link pins arrive asynchronously and are much slower than the 25 MHz system clock.
//
// Behaviour
// - Sixteen byte registers; address counter advances after every data byte transferred.
// - Link accepts bit rates up to 6.25 Mbit/s on writes; read data lags each clock fall by up to three cycles.
// - Addresses 00h and 01h are the two control registers.
// - Addresses 02h to 08h are BCD seconds to years counters.
// - Calendar counters stand still while a time register is accessed.
// - Addresses 09h to 0Ch hold the alarm settings.
// - Address 0Dh holds the offset calibration value.
// - 0Eh selects clock output and timer mode; 0Eh and 0Fh drive countdown.
// - Countdown clocked from one of four sources, 4096 Hz down to 1/60 Hz.
// - Second and minute periodic interrupts enabled in the second control register.
// - Interrupt pin pulled low open-drain while asserted, released otherwise.
// - Chip enable high selects; undriven it reads as inactive.
// - Serial output driven only while returning read data, else high impedance.
// - Serial input and output may share one wire; host releases it during reads.
// - Serial clock and data ignored while chip enable is inactive.
// - Clock output toggles only while its gate input is high.
module rtcfe_top
  import rtcfe_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic chip_enable_in,
  input wire logic serial_clock_in,
  input wire logic serial_in_in,
  input wire logic clock_output_gate_in,
  output logic serial_out_out,
  output logic serial_out_oe_b_out,
  output logic int_out,
  output logic int_oe_b_out,
  output logic clkout_out,
  output logic clkout_oe_b_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] ce_sync;
    logic [1:0] scl_sync;
    logic [1:0] din_sync;
    logic [1:0] gate_sync;
    logic scl_prev;
    logic [2:0] bit_cnt;
    logic cmd_phase;
    logic rd_mode;
    logic touched;
    logic [3:0] addr;
    logic [7:0] in_shift;
    logic [7:0] out_shift;
    logic dout_en;
    logic dout_bit;
    logic [PRE_W-1:0] pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic sec_pend;
    logic [7:0] cd_reload;
    logic irq;
    logic co_low;
    logic [15:0][7:0] regs;
  } rtcfe_state_s;

  rtcfe_state_s st;
  rtcfe_state_s next_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    if (v >= hi) begin
      return {1'b1, lo};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // ****************************************
  // Decoded events
  // ****************************************
  logic ce;
  logic scl;
  logic din;
  logic rise;
  logic fall;
  logic byte_done;
  logic [7:0] in_byte;
  logic in_time;
  logic freeze;
  logic tick_base;
  logic tick4k;
  logic tick64;
  logic tick1;
  logic sec_go;
  logic tick_min;
  logic cd_src;
  logic [8:0] step_sec;
  logic [8:0] step_min;
  logic [8:0] step_hour;
  logic [8:0] step_day;
  logic [8:0] step_wday;
  logic [8:0] step_mon;
  logic [8:0] step_year;

  // Only the second synchroniser stage is read
  assign ce = st.ce_sync[1];
  assign scl = st.scl_sync[1];
  assign din = st.din_sync[1];
  // Edges are found on the system clock; each link phase must last two cycles or more
  assign rise = ce & scl & ~st.scl_prev;
  assign fall = ce & ~scl & st.scl_prev;
  assign byte_done = rise & (st.bit_cnt == 3'd7);
  assign in_byte = {st.in_shift[6:0], din};
  assign in_time = (st.addr >= ADDR_SEC) && (st.addr <= ADDR_YEAR);
  assign freeze = st.touched | (ce & ~st.cmd_phase & in_time);

  assign tick_base = (st.pre_cnt == PRE_W'(BASE_TICK_CYC - 1)) & ~st.regs[ADDR_CTRL1][C1_STOP];
  assign tick4k = tick_base & (&st.div_cnt[3:0]);
  assign tick64 = tick_base & (&st.div_cnt[9:0]);
  assign tick1 = tick_base & (&st.div_cnt[15:0]);
  // A second that lands inside a frozen access waits in sec_pend
  assign sec_go = st.sec_pend & ~freeze;

  assign step_sec = bcd_step({1'b0, st.regs[ADDR_SEC][6:0]}, SEC_MAX, BCD_ZERO);
  assign step_min = bcd_step(st.regs[ADDR_MIN] & REG_MASK[ADDR_MIN], SEC_MAX, BCD_ZERO);
  assign step_hour = bcd_step(st.regs[ADDR_HOUR] & REG_MASK[ADDR_HOUR], HOUR_MAX, BCD_ZERO);
  assign step_day = bcd_step(st.regs[ADDR_DAY] & REG_MASK[ADDR_DAY],
                             month_days(st.regs[ADDR_MON], st.regs[ADDR_YEAR]), BCD_ONE);
  assign step_wday = bcd_step(st.regs[ADDR_WDAY] & REG_MASK[ADDR_WDAY], WDAY_MAX, BCD_ZERO);
  assign step_mon = bcd_step(st.regs[ADDR_MON] & REG_MASK[ADDR_MON], MON_MAX, BCD_ONE);
  assign step_year = bcd_step(st.regs[ADDR_YEAR], YEAR_MAX, BCD_ZERO);
  assign tick_min = sec_go & step_sec[8];

  always_comb begin
    case (st.regs[ADDR_TMR_MODE][TM_CTD_LSB +: 2])
      2'd0: cd_src = tick4k;
      2'd1: cd_src = tick64;
      2'd2: cd_src = tick1;
      default: cd_src = tick_min;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.ce_sync = {st.ce_sync[0], chip_enable_in};
    next_st.scl_sync = {st.scl_sync[0], serial_clock_in};
    next_st.din_sync = {st.din_sync[0], serial_in_in};
    next_st.gate_sync = {st.gate_sync[0], clock_output_gate_in};
    next_st.scl_prev = scl;

    // Timebase halts with the stop bit
    if (!st.regs[ADDR_CTRL1][C1_STOP]) begin
      next_st.pre_cnt = tick_base ? '0 : st.pre_cnt + PRE_W'(1);
      next_st.div_cnt = st.div_cnt + DIV_W'(tick_base);
    end

    // Calendar carry chain
    next_st.sec_pend = (st.sec_pend & freeze) | tick1;
    if (sec_go) begin
      next_st.regs[ADDR_SEC] = {st.regs[ADDR_SEC][7], step_sec[6:0]};
      if (step_sec[8]) begin
        next_st.regs[ADDR_MIN] = step_min[7:0];
        if (step_min[8]) begin
          next_st.regs[ADDR_HOUR] = step_hour[7:0];
          if (step_hour[8]) begin
            next_st.regs[ADDR_DAY] = step_day[7:0];
            next_st.regs[ADDR_WDAY] = step_wday[7:0];
            if (step_day[8]) begin
              next_st.regs[ADDR_MON] = step_mon[7:0];
              if (step_mon[8]) begin
                next_st.regs[ADDR_YEAR] = step_year[7:0];
              end
            end
          end
        end
      end
    end

    // Countdown reloads from the last value written
    if (st.regs[ADDR_TMR_MODE][TM_TE] && cd_src) begin
      if (st.regs[ADDR_CDOWN] <= 8'h01) begin
        next_st.regs[ADDR_CDOWN] = st.cd_reload;
      end else begin
        next_st.regs[ADDR_CDOWN] = st.regs[ADDR_CDOWN] - 8'h01;
      end
    end

    // Serial link
    if (!ce) begin
      next_st.bit_cnt = 3'd0;
      next_st.cmd_phase = 1'b1;
      next_st.dout_en = 1'b0;
      next_st.touched = 1'b0;
    end else begin
      next_st.touched = freeze;
      if (rise) begin
        next_st.in_shift = in_byte;
        next_st.bit_cnt = st.bit_cnt + 3'd1;
      end
      if (fall && st.dout_en) begin
        next_st.dout_bit = st.out_shift[7];
        next_st.out_shift = {st.out_shift[6:0], 1'b0};
      end
      if (byte_done && st.cmd_phase) begin
        next_st.cmd_phase = 1'b0;
        next_st.rd_mode = in_byte[CMD_READ_BIT];
        next_st.addr = in_byte[3:0];
        next_st.out_shift = st.regs[in_byte[3:0]];
        next_st.dout_en = in_byte[CMD_READ_BIT];
      end else if (byte_done) begin
        next_st.addr = st.addr + 4'h1;
        next_st.out_shift = st.regs[st.addr + 4'h1];
        if (!st.rd_mode) begin
          case (st.addr)
            ADDR_CTRL1: begin
              if (in_byte == SOFT_RESET_CODE) begin
                next_st.regs = REG_RST;
                next_st.cd_reload = REG_RST[ADDR_CDOWN];
              end else begin
                next_st.regs[ADDR_CTRL1] = in_byte & REG_MASK[ADDR_CTRL1];
              end
            end
            ADDR_CTRL2: begin
              // Flags only clear by writing zero
              next_st.regs[ADDR_CTRL2] = (in_byte & ~C2_FLAG_MASK) | (in_byte & st.regs[ADDR_CTRL2] & C2_FLAG_MASK);
            end
            ADDR_CDOWN: begin
              next_st.regs[ADDR_CDOWN] = in_byte;
              next_st.cd_reload = in_byte;
            end
            default: begin
              next_st.regs[st.addr] = in_byte & REG_MASK[st.addr];
            end
          endcase
        end
      end
    end

    // Hardware flag sets come last so they beat a clear in the same cycle
    if ((sec_go && st.regs[ADDR_CTRL2][C2_SI]) || (tick_min && st.regs[ADDR_CTRL2][C2_MI])) begin
      next_st.regs[ADDR_CTRL2][C2_MSF] = 1'b1;
    end
    if (st.regs[ADDR_TMR_MODE][TM_TE] && cd_src && st.regs[ADDR_CDOWN] <= 8'h01) begin
      next_st.regs[ADDR_CTRL2][C2_TF] = 1'b1;
    end

    // Interrupt request and clock output
    next_st.irq = (st.regs[ADDR_CTRL2][C2_MSF] & (st.regs[ADDR_CTRL2][C2_MI] | st.regs[ADDR_CTRL2][C2_SI]))
                | (st.regs[ADDR_CTRL2][C2_AF] & st.regs[ADDR_CTRL2][C2_AIE])
                | (st.regs[ADDR_CTRL2][C2_TF] & st.regs[ADDR_CTRL2][C2_TIE]);
    case (st.regs[ADDR_TMR_MODE][TM_COF_LSB +: 3])
      3'd0: next_st.co_low = ~st.div_cnt[0];
      3'd1: next_st.co_low = ~st.div_cnt[1];
      3'd2: next_st.co_low = ~st.div_cnt[2];
      3'd3: next_st.co_low = ~st.div_cnt[3];
      3'd4: next_st.co_low = ~st.div_cnt[5];
      3'd5: next_st.co_low = ~st.div_cnt[10];
      3'd6: next_st.co_low = ~st.div_cnt[15];
      default: next_st.co_low = 1'b0;
    endcase
    next_st.co_low = next_st.co_low & st.gate_sync[1];
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
      st.cmd_phase <= 1'b1;
      st.regs <= REG_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  assign serial_out_out = st.dout_bit;
  assign serial_out_oe_b_out = ~st.dout_en;
  assign int_out = 1'b0;
  assign int_oe_b_out = ~st.irq;
  assign clkout_out = 1'b0;
  assign clkout_oe_b_out = ~st.co_low;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_data_byte;
    byte_done && !st.cmd_phase;
  endsequence
  sequence s_idle_link;
    !ce;
  endsequence

  property p_addr_inc;
    s_data_byte |=> st.addr == 4'($past(st.addr) + 4'h1);
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");

  property p_addr_wrap;
    s_data_byte ##0 (st.addr == ADDR_CDOWN) |=> st.addr == ADDR_CTRL1;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap");

  property p_soft_reset;
    s_data_byte ##0 (!st.rd_mode && st.addr == ADDR_CTRL1 && in_byte == SOFT_RESET_CODE)
      |=> st.regs[ADDR_SEC] == REG_RST[ADDR_SEC] && st.regs[ADDR_TMR_MODE] == REG_RST[ADDR_TMR_MODE];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset code not honoured");

  property p_freeze;
    freeze && !byte_done |=> $stable(st.regs[ADDR_YEAR:ADDR_SEC]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("calendar moved during access");

  property p_bcd_sec;
    sec_go |=> st.regs[ADDR_SEC][3:0] <= 4'h9 && st.regs[ADDR_SEC][6:4] <= 3'h5;
  endproperty
  a_bcd_sec: assert property (p_bcd_sec) else $error("seconds left BCD range");

  property p_dout_idle;
    s_idle_link |=> serial_out_oe_b_out ##1 serial_out_oe_b_out || ce;
  endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("serial output driven while idle");

  property p_ignore_idle;
    s_idle_link |=> $stable(st.in_shift) && st.bit_cnt == 3'd0;
  endproperty
  a_ignore_idle: assert property (p_ignore_idle) else $error("link moved while deselected");

  property p_min_flag;
    tick_min && st.regs[ADDR_CTRL2][C2_MI] |=> st.regs[ADDR_CTRL2][C2_MSF] ##1 !int_oe_b_out;
  endproperty
  a_min_flag: assert property (p_min_flag) else $error("minute interrupt missing");

  property p_int_release;
    !st.regs[ADDR_CTRL2][C2_MSF] && !st.regs[ADDR_CTRL2][C2_AF] && !st.regs[ADDR_CTRL2][C2_TF]
      |=> int_oe_b_out;
  endproperty
  a_int_release: assert property (p_int_release) else $error("interrupt pin held without cause");

  property p_cd_4k;
    st.regs[ADDR_TMR_MODE][TM_TE] && st.regs[ADDR_TMR_MODE][1:0] == 2'd0 && tick4k
      && st.regs[ADDR_CDOWN] > 8'h01 && !byte_done |=> st.regs[ADDR_CDOWN] == $past(st.regs[ADDR_CDOWN]) - 8'h01;
  endproperty
  a_cd_4k: assert property (p_cd_4k) else $error("countdown did not step");

  property p_clkout_gate;
    !st.gate_sync[1] |=> clkout_oe_b_out;
  endproperty
  a_clkout_gate: assert property (p_clkout_gate) else $error("clock output active while gated");
endmodule // rtcfe_top

// file: testbench/rtcfe_host_model.sv
// Partner model: host controller that drives the three-wire serial link of the clock.
// Assumes the device samples chip enable, link clock and data with its own system clock.
module rtcfe_host_model (
  input wire logic clk_in,
  input wire logic dout_in,
  input wire logic dout_oe_b_in,
  output logic ce_out,
  output logic sclk_out,
  output logic din_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int half = 4;
  logic ce_drv = 1'b0;
  logic ce_val = 1'b0;
  logic host_drv = 1'b1;
  logic host_bit = 1'b0;
  logic rd_ok = 1'b0;
  initial sclk_out = 1'b0;
  // Undriven chip enable settles at the pull-down level
  assign ce_out = ce_drv ? ce_val : 1'b0;
  // One shared data wire; a released wire shows the inverse of its last level
  assign din_out = host_drv ? host_bit : (dout_oe_b_in ? ~host_bit : dout_in);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Idle garbage on clock and data while deselected
  task automatic noise(input logic [31:0] r);
    sclk_out = r[0];
    host_bit = r[1];
    cyc(1);
  endtask

  // Data changes while the link clock is low; returned bits taken at the rise
  task automatic xbyte(input logic [7:0] tx, input logic rel, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_out = 1'b0;
      host_drv = ~rel;
      host_bit = tx[i];
      cyc(half);
      rx[i] = din_out;
      sclk_out = 1'b1;
      cyc(half);
    end
  endtask

  task automatic frame(input logic rd, input logic [3:0] a, input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sclk_out = 1'b0;
    host_bit = 1'b0;
    rd_ok = rd;
    cyc(2);
    ce_drv = 1'b1;
    ce_val = 1'b1;
    cyc(2);
    xbyte({rd, 3'h0, a}, 1'b0, b);
    foreach (tx[i]) begin
      xbyte(tx[i], rd, b);
      rx.push_back(b);
    end
    sclk_out = 1'b0;
    cyc(half);
    ce_val = 1'b0;
    ce_drv = 1'b0;
    host_drv = 1'b1;
    // Device lets go of the data wire a few cycles after deselect
    cyc(6);
    rd_ok = 1'b0;
  endtask
endmodule // rtcfe_host_model

// file: testbench/tb_spi_rtc_register_frontend.sv
// Self-checking bench for the serial register front end of the clock.
// Assumes a 25 MHz system clock and a host partner model on the link pins.
module tb_spi_rtc_register_frontend;
  timeunit 1ns;
  timeprecision 100ps;
  import rtcfe_pkg::*;
  logic clk_sys_in;
  logic rst_b_in;
  logic clock_output_gate_in;
  logic chip_enable_in, serial_clock_in, serial_in_in;
  logic serial_out_out, serial_out_oe_b_out, int_out, int_oe_b_out, clkout_out, clkout_oe_b_out;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] mdl[16];
  logic [31:0] seed = 32'h1FDF;

  rtcfe_top rtcfe_top_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .chip_enable_in(chip_enable_in),
    .serial_clock_in(serial_clock_in), .serial_in_in(serial_in_in), .clock_output_gate_in(clock_output_gate_in),
    .serial_out_out(serial_out_out), .serial_out_oe_b_out(serial_out_oe_b_out), .int_out(int_out),
    .int_oe_b_out(int_oe_b_out), .clkout_out(clkout_out), .clkout_oe_b_out(clkout_oe_b_out));
  rtcfe_host_model rtcfe_host_model_inst (.clk_in(clk_sys_in), .dout_in(serial_out_out),
    .dout_oe_b_in(serial_out_oe_b_out), .ce_out(chip_enable_in), .sclk_out(serial_clock_in), .din_out(serial_in_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************
  // Reference model and helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      fail_count++;
    end
  endtask

  task automatic mdl_reset();
    for (int i = 0; i < 16; i++) mdl[i] = REG_RST[i];
  endtask

  // Flags in the second control byte clear on 0 and keep on 1
  task automatic mdl_write(input logic [3:0] a, input logic [7:0] d);
    if (a == ADDR_CTRL1 && d == SOFT_RESET_CODE) mdl_reset();
    else if (a == ADDR_CTRL2) mdl[a] = (d & REG_MASK[a] & ~C2_FLAG_MASK) | (mdl[a] & d & C2_FLAG_MASK);
    else mdl[a] = d & REG_MASK[a];
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    logic [7:0] r[$];
    rtcfe_host_model_inst.frame(1'b0, a, d, r);
    foreach (d[i]) mdl_write(a + 4'(i), d[i]);
  endtask

  task automatic wr1(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q[$];
    q = {d};
    wr(a, q);
  endtask

  task automatic rd(input logic [3:0] a, input int n);
    logic [7:0] z[$];
    logic [7:0] r[$];
    for (int i = 0; i < n; i++) z.push_back(8'h00);
    rtcfe_host_model_inst.frame(1'b1, a, z, r);
    foreach (r[i]) chk(r[i], mdl[a + 4'(i)], "read byte");
  endtask

  task automatic edges(input int n, output int e);
    logic p;
    e = 0;
    p = clkout_oe_b_out;
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
      if (clkout_oe_b_out !== p) e++;
      p = clkout_oe_b_out;
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Data output may only be driven inside a read frame
  always @(negedge clk_sys_in) begin
    if (rst_b_in === 1'b1 && serial_out_oe_b_out !== 1'b1 && !rtcfe_host_model_inst.rd_ok) begin
      chk(8'h00, 8'h01, "data out driven outside read");
    end
  end

  // Run is about 20k cycles; cut off at 100k
  initial begin
    #4000000;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    fail_count++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] q[$];
    int e;
    rst_b_in = 1'b0;
    clock_output_gate_in = 1'b0;
    mdl_reset();
    repeat (5) @(posedge clk_sys_in);
    #1;
    rst_b_in = 1'b1;
    rtcfe_host_model_inst.cyc(3);
    rd(4'h0, 16);
    chk({7'h00, int_oe_b_out}, 8'h01, "interrupt idle");
    done("reset_values");
    // Counters get legal BCD; timer enable kept off so no flag appears
    q = {8'(xs()), 8'h45, 8'h34, 8'h12, 8'h28, 8'h03, 8'h11, 8'h24};
    repeat (5) q.push_back(8'(xs()));
    q.push_back(8'(xs()) & 8'hF7);
    q.push_back(8'(xs()));
    wr(4'h1, q);
    repeat (200) rtcfe_host_model_inst.noise(xs());
    rd(4'h0, 16);
    done("burst_write");
    q = {8'(xs()), 8'h00, 8'(xs()), 8'(xs()) & 8'h26};
    wr(4'hD, q);
    rd(4'hE, 4);
    done("wrap");
    // Read data lags a link clock fall by up to three cycles, so full rate is driven on writes
    rtcfe_host_model_inst.half = 2;
    q = {8'(xs()), 8'(xs()), 8'(xs()), 8'(xs())};
    wr(4'h9, q);
    rtcfe_host_model_inst.half = 4;
    rd(4'h0, 16);
    done("max_rate");
    wr1(4'h0, SOFT_RESET_CODE);
    rd(4'h0, 16);
    done("soft_reset");
    wr1(4'h1, 8'h01);
    wr1(4'hF, 8'h02);
    wr1(4'hE, 8'h08);
    for (int i = 0; i < 20000 && int_oe_b_out !== 1'b0; i++) rtcfe_host_model_inst.cyc(1);
    chk({6'h00, int_out, int_oe_b_out}, 8'h00, "interrupt pulled low");
    mdl[1] = mdl[1] | 8'h04;
    wr1(4'hE, 8'h00);
    rd(4'h1, 1);
    wr1(4'h1, 8'h01);
    rtcfe_host_model_inst.cyc(4);
    chk({7'h00, int_oe_b_out}, 8'h01, "interrupt released");
    done("countdown_interrupt");
    edges(2000, e);
    chk({6'(e), clkout_out, clkout_oe_b_out}, 8'h01, "clock out gated");
    clock_output_gate_in = 1'b1;
    // Let the gate pass its synchroniser so the switch-on step is not counted
    rtcfe_host_model_inst.cyc(4);
    edges(2000, e);
    chk(8'(e >= 2000 / BASE_TICK_CYC && e <= 2000 / BASE_TICK_CYC + 1), 8'h01, "clock out toggles");
    done("clock_out");
    tally_and_finish();
  end
endmodule // tb_spi_rtc_register_frontend
